// ### core/fprf_regfile.sv
// Behaviour
// - Thirty-two 32-bit data registers in four banks; even/odd pairs hold doubles.
// - Register contents are stored and returned bit-for-bit, never converted.
// - No type checking; operands interpreted only by current instruction precision.
// - Integers are 32-bit signed or unsigned, moved unchanged.
// - Single layout: sign bit 31, exponent 30..23, fraction 22..0.
// - Double upper word: sign 31, exponent 30..20, fraction 19..0; lower word fraction.
// - Single/integer register number is four-bit high field plus one low bit.
// - Single-register transfers move exactly 32 bits either direction per instruction.
// - System transfers read any of the five system registers and write the four other than identification.
// - Single transfers copy one host word into or out of one single register.
// - Half-double transfers touch only low or only high half of a double.
// - Double pair write loads low half from first, high from second host word.
// - Paired-single write puts first word in m, second in m+1.
// - Double pair read returns low half first, high half second.
// - Paired-single read returns m first and m+1 second.
// - No floating-point exception is ever raised by any transfer.
// - Double n shares storage with singles 2n and 2n+1.
`timescale 1ns/10ps
module fprf_regfile (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_NRST,
	// Transfer request
	input wire logic I_XFER_VALID,
	input wire fprf_pkg::fprf_op_e I_XFER_OP,
	input wire logic [fprf_pkg::HIGH_FIELD_W-1:0] I_REG_HIGH_FIELD,
	input wire logic I_REG_LOW_BIT,
	input wire logic [2:0] I_SYSREG_SEL,
	input wire logic [fprf_pkg::WORD_W-1:0] I_HOST_FIRST,
	input wire logic [fprf_pkg::WORD_W-1:0] I_HOST_SECOND,
	// Transfer answer
	output logic O_RESULT_VALID,
	output logic O_RESULT_PAIR,
	output logic [fprf_pkg::WORD_W-1:0] O_HOST_FIRST,
	output logic [fprf_pkg::WORD_W-1:0] O_HOST_SECOND,
	output logic O_FP_EXCEPTION,
	// Decoded view: single fields of the first result word, double fields of the second
	output logic O_SP_SIGN,
	output logic [7:0] O_SP_EXPONENT,
	output logic [22:0] O_SP_FRACTION,
	output logic O_DP_SIGN,
	output logic [10:0] O_DP_EXPONENT,
	output logic [19:0] O_DP_FRACTION_HI
);
	import fprf_pkg::*;

	// ---------------------------------------------------------------
	// Storage and register number decode
	// ---------------------------------------------------------------
	// data register array
	logic [WORD_W-1:0] data_q [REG_COUNT];
	logic [WORD_W-1:0] status_ctrl_q;
	logic [WORD_W-1:0] exception_q;
	logic [WORD_W-1:0] exc_instr_q;
	logic [WORD_W-1:0] exc_instr_two_q;

	logic [REG_NUM_W-1:0] single_num;
	logic [REG_NUM_W-1:0] single_next;
	logic [REG_NUM_W-1:0] double_lo;
	logic [REG_NUM_W-1:0] double_hi;
	logic is_write;

	// single number from high field and low bit
	assign single_num = {I_REG_HIGH_FIELD, I_REG_LOW_BIT};
	// The pair wraps from 31 back to 0, a case software should avoid.
	assign single_next = single_num + 5'h01;
	// double selected by high field only
	// low half even, high half odd
	assign double_lo = {I_REG_HIGH_FIELD, 1'b0};
	assign double_hi = {I_REG_HIGH_FIELD, 1'b1};

	// ---------------------------------------------------------------
	// Data register writes
	// ---------------------------------------------------------------
	// Each entry checks whether this transfer writes it; values are
	// stored raw, whatever format they carry.
	always_comb begin
		is_write = I_XFER_VALID && (I_XFER_OP == OP_SINGLE_WRITE_XFER ||
			I_XFER_OP == OP_DOUBLE_LOW_WRITE_XFER || I_XFER_OP == OP_DOUBLE_HIGH_WRITE_XFER ||
			I_XFER_OP == OP_DOUBLE_PAIR_WRITE_XFER || I_XFER_OP == OP_SINGLE_PAIR_WRITE_XFER);
	end

	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_entry
			localparam logic [REG_NUM_W-1:0] IDX = REG_NUM_W'(gi);
			logic wr_en;
			logic [WORD_W-1:0] wr_data;
			always_comb begin
				wr_en = 1'b0;
				wr_data = I_HOST_FIRST;
				if (is_write) begin
					case (I_XFER_OP)
						OP_SINGLE_WRITE_XFER: begin
							wr_en = (single_num == IDX);
						end
						OP_DOUBLE_LOW_WRITE_XFER: begin
							wr_en = (double_lo == IDX);
						end
						OP_DOUBLE_HIGH_WRITE_XFER: begin
							wr_en = (double_hi == IDX);
						end
						OP_DOUBLE_PAIR_WRITE_XFER: begin
							if (double_lo == IDX) begin
								wr_en = 1'b1;
							end else if (double_hi == IDX) begin
								wr_en = 1'b1;
								wr_data = I_HOST_SECOND;
							end
						end
						// first to m, second to m+1
						OP_SINGLE_PAIR_WRITE_XFER: begin
							if (single_num == IDX) begin
								wr_en = 1'b1;
							end else if (single_next == IDX) begin
								wr_en = 1'b1;
								wr_data = I_HOST_SECOND;
							end
						end
						default: begin
							wr_en = 1'b0;
						end
					endcase
				end
			end
			always_ff @(posedge I_CLK or negedge I_NRST) begin
				if (!I_NRST) begin
					data_q[gi] <= DATA_RESET;
				end else if (wr_en) begin
					data_q[gi] <= wr_data;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// System registers
	// ---------------------------------------------------------------
	// The identification register is read-only; writes to it are dropped.
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			status_ctrl_q <= SYS_RESET;
			exception_q <= SYS_RESET;
			exc_instr_q <= SYS_RESET;
			exc_instr_two_q <= SYS_RESET;
		end else if (I_XFER_VALID && I_XFER_OP == OP_SYSREG_WRITE_XFER) begin
			if (I_SYSREG_SEL == SYS_STATUS_CTRL) begin
				status_ctrl_q <= I_HOST_FIRST;
			end else if (I_SYSREG_SEL == SYS_EXCEPTION) begin
				exception_q <= I_HOST_FIRST;
			end else if (I_SYSREG_SEL == SYS_EXC_INSTR) begin
				exc_instr_q <= I_HOST_FIRST;
			end else if (I_SYSREG_SEL == SYS_EXC_INSTR_TWO) begin
				exc_instr_two_q <= I_HOST_FIRST;
			end
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	logic [WORD_W-1:0] rd_first;
	logic [WORD_W-1:0] rd_second;
	logic rd_pair;
	logic rd_any;

	always_comb begin
		rd_first = DATA_RESET;
		rd_second = DATA_RESET;
		rd_pair = 1'b0;
		rd_any = 1'b1;
		case (I_XFER_OP)
			OP_SYSREG_READ_XFER: begin
				if (I_SYSREG_SEL == SYS_ID) begin
					rd_first = SYSTEM_ID_VALUE;
				end else if (I_SYSREG_SEL == SYS_STATUS_CTRL) begin
					rd_first = status_ctrl_q;
				end else if (I_SYSREG_SEL == SYS_EXCEPTION) begin
					rd_first = exception_q;
				end else if (I_SYSREG_SEL == SYS_EXC_INSTR) begin
					rd_first = exc_instr_q;
				end else if (I_SYSREG_SEL == SYS_EXC_INSTR_TWO) begin
					rd_first = exc_instr_two_q;
				end
			end
			OP_SINGLE_READ_XFER: begin
				rd_first = data_q[single_num];
			end
			OP_DOUBLE_LOW_READ_XFER: begin
				rd_first = data_q[double_lo];
			end
			OP_DOUBLE_HIGH_READ_XFER: begin
				rd_first = data_q[double_hi];
			end
			OP_DOUBLE_PAIR_READ_XFER: begin
				rd_first = data_q[double_lo];
				rd_second = data_q[double_hi];
				rd_pair = 1'b1;
			end
			OP_SINGLE_PAIR_READ_XFER: begin
				rd_first = data_q[single_num];
				rd_second = data_q[single_next];
				rd_pair = 1'b1;
			end
			default: begin
				rd_any = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registered answer
	// ---------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RESULT_VALID <= 1'b0;
			O_RESULT_PAIR <= 1'b0;
			O_HOST_FIRST <= DATA_RESET;
			O_HOST_SECOND <= DATA_RESET;
		end else begin
			O_RESULT_VALID <= I_XFER_VALID && rd_any;
			O_RESULT_PAIR <= I_XFER_VALID && rd_pair;
			if (I_XFER_VALID && rd_any) begin
				O_HOST_FIRST <= rd_first;
				O_HOST_SECOND <= rd_second;
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_FP_EXCEPTION <= 1'b0;
		end else begin
			O_FP_EXCEPTION <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Field view: single of the first read word, double of the second
	// ---------------------------------------------------------------
	// both views shown; the consumer picks per instruction
	always_ff @(posedge I_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_SP_SIGN <= 1'b0;
			O_SP_EXPONENT <= 8'h00;
			O_SP_FRACTION <= 23'h000000;
			O_DP_SIGN <= 1'b0;
			O_DP_EXPONENT <= 11'h000;
			O_DP_FRACTION_HI <= 20'h00000;
		end else if (I_XFER_VALID && rd_any) begin
			O_SP_SIGN <= rd_first[SP_SIGN_POS];
			O_SP_EXPONENT <= rd_first[SP_EXP_MSB:SP_EXP_LSB];
			O_SP_FRACTION <= rd_first[SP_FRAC_MSB:SP_FRAC_LSB];
			O_DP_SIGN <= rd_second[DP_SIGN_POS];
			O_DP_EXPONENT <= rd_second[DP_EXP_MSB:DP_EXP_LSB];
			O_DP_FRACTION_HI <= rd_second[DP_FRAC_HI_MSB:DP_FRAC_HI_LSB];
		end
	end

	// shared storage: double views index the same array
endmodule

// ### core/fprf_pkg.sv
package fprf_pkg;

	// ---------------------------------------------------------------
	// Register file geometry
	// ---------------------------------------------------------------
	localparam int unsigned REG_COUNT = 32;
	localparam int unsigned WORD_W = 32;
	localparam int unsigned REG_NUM_W = 5;
	localparam int unsigned HIGH_FIELD_W = 4;
	localparam int unsigned BANK_COUNT = 4;
	localparam int unsigned REGS_PER_BANK = 8;
	localparam logic [WORD_W-1:0] DATA_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Single-precision field positions
	// ---------------------------------------------------------------
	localparam int unsigned SP_SIGN_POS = 31;
	localparam int unsigned SP_EXP_MSB = 30;
	localparam int unsigned SP_EXP_LSB = 23;
	localparam int unsigned SP_FRAC_MSB = 22;
	localparam int unsigned SP_FRAC_LSB = 0;

	// ---------------------------------------------------------------
	// Double-precision upper word field positions
	// ---------------------------------------------------------------
	localparam int unsigned DP_SIGN_POS = 31;
	localparam int unsigned DP_EXP_MSB = 30;
	localparam int unsigned DP_EXP_LSB = 20;
	localparam int unsigned DP_FRAC_HI_MSB = 19;
	localparam int unsigned DP_FRAC_HI_LSB = 0;

	// ---------------------------------------------------------------
	// System register selector and reset values
	// ---------------------------------------------------------------
	localparam logic [2:0] SYS_ID = 3'h0;
	localparam logic [2:0] SYS_STATUS_CTRL = 3'h1;
	localparam logic [2:0] SYS_EXCEPTION = 3'h2;
	localparam logic [2:0] SYS_EXC_INSTR = 3'h3;
	localparam logic [2:0] SYS_EXC_INSTR_TWO = 3'h4;
	// Identification value is arbitrary.
	localparam logic [WORD_W-1:0] SYSTEM_ID_VALUE = 32'h0000_5A01;
	localparam logic [WORD_W-1:0] SYS_RESET = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Transfer operations
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SYSREG_WRITE_XFER = 4'h1,
		OP_SYSREG_READ_XFER = 4'h2,
		OP_DOUBLE_LOW_WRITE_XFER = 4'h3,
		OP_DOUBLE_HIGH_WRITE_XFER = 4'h4,
		OP_SINGLE_WRITE_XFER = 4'h5,
		OP_SINGLE_READ_XFER = 4'h6,
		OP_DOUBLE_LOW_READ_XFER = 4'h7,
		OP_DOUBLE_HIGH_READ_XFER = 4'h8,
		OP_DOUBLE_PAIR_WRITE_XFER = 4'h9,
		OP_SINGLE_PAIR_WRITE_XFER = 4'hA,
		OP_DOUBLE_PAIR_READ_XFER = 4'hB,
		OP_SINGLE_PAIR_READ_XFER = 4'hC
	} fprf_op_e;

endpackage

// ### bench/fprf_regfile_props.sv
`timescale 1ns/10ps
module fprf_regfile_props (
	// Clock, reset, request
	input wire logic I_CLK,
	input wire logic I_NRST,
	input wire logic I_XFER_VALID,
	input wire fprf_pkg::fprf_op_e I_XFER_OP,
	input wire logic [2:0] I_SYSREG_SEL,
	// Answer
	input wire logic O_RESULT_VALID,
	input wire logic O_RESULT_PAIR,
	input wire logic [31:0] O_HOST_FIRST,
	input wire logic [31:0] O_HOST_SECOND,
	input wire logic O_FP_EXCEPTION,
	input wire logic O_SP_SIGN,
	input wire logic [7:0] O_SP_EXPONENT,
	input wire logic [22:0] O_SP_FRACTION,
	input wire logic O_DP_SIGN,
	input wire logic [10:0] O_DP_EXPONENT,
	input wire logic [19:0] O_DP_FRACTION_HI
);
	import fprf_pkg::*;
	logic rd;
	logic pr;
	logic sr;
	assign pr = I_XFER_VALID && I_XFER_OP inside {OP_DOUBLE_PAIR_READ_XFER, OP_SINGLE_PAIR_READ_XFER};
	assign sr = I_XFER_VALID && I_XFER_OP inside {OP_SYSREG_READ_XFER, OP_SINGLE_READ_XFER,
		OP_DOUBLE_LOW_READ_XFER, OP_DOUBLE_HIGH_READ_XFER};
	assign rd = pr || sr;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_NRST);
	a_no_exception: assert property (!O_FP_EXCEPTION) else $error("exception raised");
	a_read_answered: assert property (rd |=> O_RESULT_VALID) else $error("no answer");
	a_write_quiet: assert property (I_XFER_VALID && !rd |=> !O_RESULT_VALID) else $error("stray answer");
	a_pair_flag: assert property (rd |=> O_RESULT_PAIR == $past(pr)) else $error("pair flag");
	a_single_second: assert property (sr |=> O_HOST_SECOND == 32'h0) else $error("second word");
	a_sp_fields: assert property (O_RESULT_VALID |->
		{O_SP_SIGN, O_SP_EXPONENT, O_SP_FRACTION} == O_HOST_FIRST) else $error("single fields");
	a_dp_fields: assert property (O_RESULT_VALID && O_RESULT_PAIR |->
		{O_DP_SIGN, O_DP_EXPONENT, O_DP_FRACTION_HI} == O_HOST_SECOND) else $error("double fields");
	a_data_stands: assert property (!O_RESULT_VALID |->
		$stable(O_HOST_FIRST) && $stable(O_HOST_SECOND)) else $error("data moved");
	a_id_read: assert property (I_XFER_VALID && I_XFER_OP == OP_SYSREG_READ_XFER && I_SYSREG_SEL == SYS_ID
		|=> O_HOST_FIRST == SYSTEM_ID_VALUE) else $error("id value");
endmodule
bind fprf_regfile fprf_regfile_props fprf_regfile_props_inst (.I_CLK(I_CLK), .I_NRST(I_NRST),
	.I_XFER_VALID(I_XFER_VALID), .I_XFER_OP(I_XFER_OP), .I_SYSREG_SEL(I_SYSREG_SEL),
	.O_RESULT_VALID(O_RESULT_VALID), .O_RESULT_PAIR(O_RESULT_PAIR), .O_HOST_FIRST(O_HOST_FIRST),
	.O_HOST_SECOND(O_HOST_SECOND), .O_FP_EXCEPTION(O_FP_EXCEPTION), .O_SP_SIGN(O_SP_SIGN),
	.O_SP_EXPONENT(O_SP_EXPONENT), .O_SP_FRACTION(O_SP_FRACTION), .O_DP_SIGN(O_DP_SIGN),
	.O_DP_EXPONENT(O_DP_EXPONENT), .O_DP_FRACTION_HI(O_DP_FRACTION_HI));

// ### bench/fprf_host.sv
`timescale 1ns/10ps
module fprf_host (
	// Clock and answer
	input wire logic i_clk,
	input wire logic i_rvalid,
	input wire logic i_rpair,
	input wire logic [31:0] i_rfirst,
	input wire logic [31:0] i_rsecond,
	// Request
	output logic o_valid,
	output fprf_pkg::fprf_op_e o_op,
	output logic [3:0] o_high,
	output logic o_low,
	output logic [2:0] o_sel,
	output logic [31:0] o_first,
	output logic [31:0] o_second
);
	import fprf_pkg::*;
	initial begin
		o_valid = 1'b0;
		o_op = OP_NONE;
		o_high = 4'h0;
		o_low = 1'b0;
		o_sel = 3'h0;
		o_first = 32'h0;
		o_second = 32'h0;
	end
	// one word or one pair per request
	task automatic xfer(input fprf_op_e op, input logic [4:0] n, input logic [2:0] s, input logic [31:0] a,
		input logic [31:0] b, output logic [31:0] r1, output logic [31:0] r2, output logic [1:0] f);
		@(negedge i_clk);
		o_valid = 1'b1;
		o_op = op;
		o_high = n[4:1];
		o_low = (op inside {OP_DOUBLE_LOW_WRITE_XFER, OP_DOUBLE_HIGH_WRITE_XFER, OP_DOUBLE_LOW_READ_XFER,
			OP_DOUBLE_HIGH_READ_XFER, OP_DOUBLE_PAIR_WRITE_XFER, OP_DOUBLE_PAIR_READ_XFER}) ? 1'b0 : n[0];
		o_sel = s;
		o_first = a;
		o_second = b;
		@(negedge i_clk);
		f = {i_rvalid, i_rpair};
		r1 = i_rfirst;
		r2 = i_rsecond;
		o_valid = 1'b0;
		o_op = OP_NONE;
		o_first = ~a;
		o_second = ~b;
	endtask
endmodule

// ### bench/fprf_regfile_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module fprf_regfile_tb;
	import fprf_pkg::*;
	int num_errors = 0;
	int checks_done = 0;
	logic clk, nrst, v, lo, rv, rp, ex, sps, dps;
	fprf_op_e op;
	logic [3:0] hi;
	logic [2:0] sel;
	logic [7:0] spe;
	logic [10:0] dpe;
	logic [22:0] spf;
	logic [19:0] dpf;
	logic [31:0] a, b, r1, r2;
	fprf_regfile fprf_regfile_inst (.I_CLK(clk), .I_NRST(nrst), .I_XFER_VALID(v), .I_XFER_OP(op),
		.I_REG_HIGH_FIELD(hi), .I_REG_LOW_BIT(lo), .I_SYSREG_SEL(sel), .I_HOST_FIRST(a), .I_HOST_SECOND(b),
		.O_RESULT_VALID(rv), .O_RESULT_PAIR(rp), .O_HOST_FIRST(r1), .O_HOST_SECOND(r2), .O_FP_EXCEPTION(ex),
		.O_SP_SIGN(sps), .O_SP_EXPONENT(spe), .O_SP_FRACTION(spf), .O_DP_SIGN(dps), .O_DP_EXPONENT(dpe),
		.O_DP_FRACTION_HI(dpf));
	fprf_host fprf_host_inst (.i_clk(clk), .i_rvalid(rv), .i_rpair(rp), .i_rfirst(r1), .i_rsecond(r2),
		.o_valid(v), .o_op(op), .o_high(hi), .o_low(lo), .o_sel(sel), .o_first(a), .o_second(b));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic wr(fprf_op_e o, logic [4:0] n, logic [2:0] s, logic [31:0] x, logic [31:0] y);
		logic [31:0] q1, q2;
		logic [1:0] f;
		fprf_host_inst.xfer(o, n, s, x, y, q1, q2, f);
		`CHK(f, 2'b00)
	endtask
	task automatic rd(fprf_op_e o, logic [4:0] n, logic [2:0] s, logic [31:0] e1, logic [31:0] e2, logic p);
		logic [31:0] q1, q2;
		logic [1:0] f;
		fprf_host_inst.xfer(o, n, s, 32'h0, 32'h0, q1, q2, f);
		`CHK(f, {1'b1, p})
		`CHK(q1, e1)
		`CHK(q2, e2)
	endtask
	function automatic logic [31:0] pat(int i);
		return 32'h8000_0000 ^ (i * 32'h0102_0409);
	endfunction
	task automatic t_singles();
		for (int i = 0; i < 32; i++) wr(OP_SINGLE_WRITE_XFER, i[4:0], 3'h0, pat(i), 32'h0);
		for (int i = 0; i < 32; i++) rd(OP_SINGLE_READ_XFER, i[4:0], 3'h0, pat(i), 32'h0, 1'b0);
	endtask
	task automatic t_halves();
		wr(OP_DOUBLE_LOW_WRITE_XFER, 5'h0A, 3'h0, 32'h1111_2222, 32'h0);
		wr(OP_DOUBLE_HIGH_WRITE_XFER, 5'h0A, 3'h0, 32'hBFF0_0000, 32'h0);
		rd(OP_SINGLE_READ_XFER, 5'h0A, 3'h0, 32'h1111_2222, 32'h0, 1'b0);
		rd(OP_SINGLE_READ_XFER, 5'h0B, 3'h0, 32'hBFF0_0000, 32'h0, 1'b0);
		wr(OP_DOUBLE_LOW_WRITE_XFER, 5'h0A, 3'h0, 32'hFFFF_FFFF, 32'h0);
		rd(OP_DOUBLE_HIGH_READ_XFER, 5'h0A, 3'h0, 32'hBFF0_0000, 32'h0, 1'b0);
		rd(OP_DOUBLE_LOW_READ_XFER, 5'h0A, 3'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
		rd(OP_SINGLE_READ_XFER, 5'h0C, 3'h0, pat(12), 32'h0, 1'b0);
	endtask
	task automatic t_pairs();
		wr(OP_DOUBLE_PAIR_WRITE_XFER, 5'h06, 3'h0, 32'h0000_0001, 32'hC009_21FB);
		rd(OP_SINGLE_PAIR_READ_XFER, 5'h06, 3'h0, 32'h0000_0001, 32'hC009_21FB, 1'b1);
		wr(OP_SINGLE_PAIR_WRITE_XFER, 5'h0D, 3'h0, 32'h3F80_0000, 32'h7FC0_0001);
		rd(OP_SINGLE_READ_XFER, 5'h0E, 3'h0, 32'h7FC0_0001, 32'h0, 1'b0);
		rd(OP_DOUBLE_PAIR_READ_XFER, 5'h0C, 3'h0, pat(12), 32'h3F80_0000, 1'b1);
		`CHK(dpe, 11'h3F8)
		`CHK(spe, pat(12) >> 23 & 32'hFF)
		rd(OP_DOUBLE_PAIR_READ_XFER, 5'h06, 3'h0, 32'h0000_0001, 32'hC009_21FB, 1'b1);
	endtask
	task automatic t_sys();
		rd(OP_SYSREG_READ_XFER, 5'h0, SYS_STATUS_CTRL, SYS_RESET, 32'h0, 1'b0);
		for (int s = 1; s < 5; s++) wr(OP_SYSREG_WRITE_XFER, 5'h0, s[2:0], 32'hA5C3_0000 + s, 32'h0);
		for (int s = 1; s < 5; s++) rd(OP_SYSREG_READ_XFER, 5'h0, s[2:0], 32'hA5C3_0000 + s, 32'h0, 1'b0);
		wr(OP_SYSREG_WRITE_XFER, 5'h0, SYS_ID, 32'hFFFF_FFFF, 32'h0);
		rd(OP_SYSREG_READ_XFER, 5'h0, SYS_ID, SYSTEM_ID_VALUE, 32'h0, 1'b0);
		rd(OP_SYSREG_READ_XFER, 5'h0, 3'h5, 32'h0, 32'h0, 1'b0);
		wr(OP_NONE, 5'h0, 3'h0, 32'h0, 32'h0);
	endtask
	task automatic results();
		if (num_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#(2000 * 100);
		num_errors++;
		results();
	end
	initial begin
		nrst = 1'b0;
		repeat (6) @(negedge clk);
		nrst = 1'b1;
		rd(OP_SINGLE_READ_XFER, 5'h1F, 3'h0, DATA_RESET, 32'h0, 1'b0);
		t_sys();
		t_singles();
		t_halves();
		t_pairs();
		`CHK(ex, 1'b0)
		results();
	end
endmodule
